// ===== design/qpw_dev.sv
// pot device end: two-wire slave, page write and move/read
// Operation
// [RULE1] row holds channels 0..3, row from select bits
// [RULE2] master sets nonvolatile select before page write
// [RULE3] page write may carry up to four bytes
// [RULE4] ack each byte, bump channel, keep row
// [RULE5] channel wraps from 3 to 0
// [RULE6] extra bytes overwrite buffered channel byte
// [RULE7] stop commits; bus ignored while writing
// [RULE8] write-protect low discards the page
// [RULE9] written bytes to wipers, others from row
// [RULE10] read loads all wipers from selected row
// [RULE11] random read: addr W, reg, restart, addr R
// [RULE12] keep sending while master acknowledges
// [RULE13] master stops after last wanted byte
// [RULE14] first read byte from channel and select bits
// [RULE15] read bumps channel, wraps 3 to 0
// [RULE16] pointer resets to channel 0
// [RULE17] select: bit0 nonvolatile, bits2:1 row, reset 0
// [RULE18] address 0..3 channels, 7 select register
// [RULE19] busy writing: no answer, data released
// [RULE20] write cycle lasts fixed cycle count
`timescale 1ns/1ps
module qpw_dev
   import qpw_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = DEV_ADDR_DEF,
   parameter int NV_CYC = NVW_CYCLES
)
(
   input wire logic mclk_i,        // 200 MHz clock
   input wire logic arst_n_i,      // async reset, active low
   qpw_if.dev bus,                 // two-wire link
   input wire logic wp_n_i,        // write protect, low blocks commit
   output logic [31:0] wiper_o,    // wiper counters, channel 0 in [7:0]
   output logic nv_busy_o          // nonvolatile write cycle running
);
   logic [1:0] scl_s;
   logic [1:0] sda_s;
   logic [1:0] wp_s;
   logic scl_d;
   logic sda_d;
   qpw_dst_e state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] sh_reg;
   logic in_ack_reg;
   logic mack_reg;
   logic drv_reg;
   logic [31:0] nvc_reg;
   logic [2:0] tgt_reg;
   logic [2:0] select_register_reg;
   logic [1:0] pot_channel_reg;
   logic [7:0] wiper_counter_reg [CHANNELS];
   logic [7:0] stored_wiper_reg [CHANNELS][CHANNELS];
   logic [7:0] pbuf_reg [CHANNELS];
   logic [3:0] pval_reg;
   logic scl_rise, scl_fall, start_ev, stop_ev, rx_st, byte_ev, adr_hit;
   logic wr_ev, ld_ev, commit;
   logic [1:0] row;
   logic nv_sel;
   logic [7:0] rd_byte;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         scl_s <= 2'h3;
         sda_s <= 2'h3;
         wp_s <= 2'h0;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_s <= {scl_s[0], bus.scl};
         sda_s <= {sda_s[0], bus.sda};
         wp_s <= {wp_s[0], wp_n_i};
         scl_d <= scl_s[1];
         sda_d <= sda_s[1];
      end
   end

   assign scl_rise = scl_s[1] & ~scl_d;
   assign scl_fall = ~scl_s[1] & scl_d;
   assign start_ev = scl_s[1] & scl_d & sda_d & ~sda_s[1];
   assign stop_ev = scl_s[1] & scl_d & ~sda_d & sda_s[1];
   assign rx_st = (state_reg == D_SLV) || (state_reg == D_REG) || (state_reg == D_WDAT);
   assign byte_ev = rx_st & scl_fall & (bit_cnt_reg == 4'h8) & ~in_ack_reg;
   assign adr_hit = (sh_reg[7:1] == SLAVE_ADDR);
   assign wr_ev = byte_ev & (state_reg == D_WDAT);
   assign ld_ev = (state_reg == D_RDAT) & scl_fall & in_ack_reg & mack_reg;
   assign row = select_register_reg[SR_ROW_LSB +: 2];                             // [RULE1]
   assign nv_sel = select_register_reg[SR_NV_BIT];                                 // [RULE17]
   assign rd_byte = nv_sel ? stored_wiper_reg[row][pot_channel_reg]
                           : wiper_counter_reg[pot_channel_reg];                  // [RULE14]
   // every buffered byte of a blocked page is simply dropped
   assign commit = stop_ev & (state_reg == D_WDAT) & (|pval_reg) & wp_s[1];       // [RULE7] [RULE8]

   // ----------------------------------------
   // bit-level protocol engine
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_reg <= D_IDLE;
         bit_cnt_reg <= 4'h0;
         sh_reg <= 8'h00;
         in_ack_reg <= 1'b0;
         mack_reg <= 1'b0;
         drv_reg <= 1'b0;
         nvc_reg <= 32'h0;
      end
      else if (state_reg == D_NVW)
      begin
         // no start, stop or bit is seen until the cycle ends
         drv_reg <= 1'b0;                                                          // [RULE19]
         if (nvc_reg == 32'h0)
            state_reg <= D_IDLE;                                                   // [RULE20]
         else
            nvc_reg <= nvc_reg - 32'h1;
      end
      else if (start_ev)
      begin
         state_reg <= D_SLV;
         bit_cnt_reg <= 4'h0;
         in_ack_reg <= 1'b0;
         drv_reg <= 1'b0;
      end
      else if (stop_ev)
      begin
         drv_reg <= 1'b0;
         in_ack_reg <= 1'b0;
         if (commit)
         begin
            state_reg <= D_NVW;                                                    // [RULE7]
            nvc_reg <= 32'(NV_CYC - 1);
         end
         else
            state_reg <= D_IDLE;
      end
      else if (state_reg == D_RDAT)
      begin
         if (scl_rise && in_ack_reg)
            mack_reg <= ~sda_s[1];                                                 // [RULE12]
         else if (scl_rise && bit_cnt_reg < 4'h8)
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         else if (ld_ev)
         begin
            sh_reg <= rd_byte;
            drv_reg <= ~rd_byte[7];
            bit_cnt_reg <= 4'h0;
            in_ack_reg <= 1'b0;
         end
         else if (scl_fall && in_ack_reg)
         begin
            state_reg <= D_IDLE;                                                   // [RULE13]
            drv_reg <= 1'b0;
         end
         else if (scl_fall && bit_cnt_reg == 4'h8)
         begin
            drv_reg <= 1'b0;
            in_ack_reg <= 1'b1;
         end
         else if (scl_fall)
         begin
            sh_reg <= {sh_reg[6:0], 1'b0};
            drv_reg <= ~sh_reg[6];
         end
      end
      else if (rx_st)
      begin
         if (scl_rise && !in_ack_reg && bit_cnt_reg < 4'h8)
         begin
            sh_reg <= {sh_reg[6:0], sda_s[1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end
         else if (byte_ev)
         begin
            in_ack_reg <= 1'b1;
            drv_reg <= 1'b1;                                                       // [RULE4]
            if (state_reg == D_SLV)
            begin
               if (!adr_hit)
               begin
                  state_reg <= D_IDLE;
                  in_ack_reg <= 1'b0;
                  drv_reg <= 1'b0;
               end
               else if (sh_reg[0])
               begin
                  state_reg <= D_RDAT;                                             // [RULE11]
                  mack_reg <= 1'b1;
               end
               else
                  state_reg <= D_REG;
            end
            else if (state_reg == D_REG)
               state_reg <= D_WDAT;
         end
         else if (scl_fall && in_ack_reg)
         begin
            in_ack_reg <= 1'b0;
            drv_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
         end
      end
   end

   // ----------------------------------------
   // register file and page buffer
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         select_register_reg <= SR_RST;                                            // [RULE17]
         pot_channel_reg <= CH_RST;                                                // [RULE16]
         tgt_reg <= 3'h0;
         pval_reg <= 4'h0;
         for (int i = 0; i < CHANNELS; i++)
         begin
            wiper_counter_reg[i] <= WIPER_RST;
            pbuf_reg[i] <= 8'h00;
            for (int j = 0; j < CHANNELS; j++)
               stored_wiper_reg[j][i] <= STORED_RST;
         end
      end
      else if (state_reg != D_NVW)
      begin
         if (start_ev || (stop_ev && !commit))
            pval_reg <= 4'h0;                                                      // [RULE8]
         else if (commit)
         begin
            pval_reg <= 4'h0;
            for (int i = 0; i < CHANNELS; i++)
            begin
               if (pval_reg[i])
               begin
                  stored_wiper_reg[row][i] <= pbuf_reg[i];
                  wiper_counter_reg[i] <= pbuf_reg[i];                             // [RULE9]
               end
               else
                  wiper_counter_reg[i] <= stored_wiper_reg[row][i];                // [RULE9]
            end
         end
         else if (byte_ev && state_reg == D_REG)
         begin
            // reserved address bits are ignored
            tgt_reg <= sh_reg[2:0];                                                // [RULE18]
            if (!sh_reg[2])
               pot_channel_reg <= sh_reg[1:0];
         end
         else if (wr_ev && tgt_reg == ADDR_SELECT)
         begin
            select_register_reg <= sh_reg[2:0];
            if (sh_reg[SR_NV_BIT])
               for (int i = 0; i < CHANNELS; i++)
                  wiper_counter_reg[i] <= stored_wiper_reg[sh_reg[SR_ROW_LSB +: 2]][i];
         end
         else if (wr_ev && !tgt_reg[2])
         begin
            if (nv_sel)
            begin
               pbuf_reg[pot_channel_reg] <= sh_reg;                                // [RULE6]
               pval_reg[pot_channel_reg] <= 1'b1;
            end
            else
               wiper_counter_reg[pot_channel_reg] <= sh_reg;
            pot_channel_reg <= pot_channel_reg + 2'h1;                             // [RULE4] [RULE5]
         end
         else if (ld_ev)
         begin
            pot_channel_reg <= pot_channel_reg + 2'h1;                             // [RULE15]
            if (nv_sel)
               for (int i = 0; i < CHANNELS; i++)
                  wiper_counter_reg[i] <= stored_wiper_reg[row][i];                // [RULE10]
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_comb
   begin
      for (int i = 0; i < CHANNELS; i++)
         wiper_o[8*i +: 8] = wiper_counter_reg[i];
   end

   assign nv_busy_o = (state_reg == D_NVW);
   assign bus.dev_sda_o = 1'b0;
   assign bus.dev_sda_oe_n = ~drv_reg;
endmodule

// ===== design/qpw_host.sv
// host end: two-wire master for page write and random read
`timescale 1ns/1ps
module qpw_host
   import qpw_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = DEV_ADDR_DEF,
   parameter int QTR = QTR_CYCLES
)
(
   input wire logic mclk_i,        // 200 MHz clock
   input wire logic arst_n_i,      // async reset, active low
   qpw_if.host bus,                // two-wire link
   input wire logic req_i,         // start a transfer, taken when not busy
   input wire logic rd_i,          // 1 random read, 0 write
   input wire logic [2:0] reg_i,   // address byte value
   input wire logic [2:0] cnt_i,   // data bytes, 1..7 (0 gives 8)
   input wire logic [31:0] wdata_i, // write bytes, byte k in [8j+7:8j] with j = k mod 4
   output logic busy_o,            // transfer running
   output logic done_o,            // one-cycle end pulse
   output logic nack_o,            // device refused a byte
   output logic [31:0] rdata_o     // read bytes, byte k mod 4
);
   logic [1:0] sda_s;
   qpw_hst_e st_reg;
   qpw_ph_e ph_reg;
   logic [1:0] q_reg;
   logic [15:0] div_reg;
   logic [3:0] bitn_reg;
   logic [7:0] tx_reg;
   logic [7:0] rx_reg;
   logic [2:0] idx_reg;
   logic ackb_reg;
   logic scl_reg;
   logic sda_reg;
   logic rd_reg;
   logic [2:0] regad_reg;
   logic [2:0] cnt_reg;
   logic [31:0] wd_reg;
   logic tick, last, rxm;

   assign tick = (st_reg != H_IDLE) && (div_reg == 16'h0);
   assign last = (idx_reg == cnt_reg - 3'h1);
   assign rxm = (ph_reg == P_RDAT);

   // ----------------------------------------
   // sda synchroniser and quarter-bit divider
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         sda_s <= 2'h3;
      else
         sda_s <= {sda_s[0], bus.sda};
   end

   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         div_reg <= 16'h0;
      else if (st_reg == H_IDLE || tick)
         div_reg <= 16'(QTR - 1);
      else
         div_reg <= div_reg - 16'h1;
   end

   // ----------------------------------------
   // transfer sequencer
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         st_reg <= H_IDLE;
         ph_reg <= P_SLAW;
         q_reg <= 2'h0;
         bitn_reg <= 4'h0;
         tx_reg <= 8'h00;
         rx_reg <= 8'h00;
         idx_reg <= 3'h0;
         ackb_reg <= 1'b1;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         rd_reg <= 1'b0;
         regad_reg <= 3'h0;
         cnt_reg <= 3'h0;
         wd_reg <= 32'h0;
         done_o <= 1'b0;
         nack_o <= 1'b0;
         rdata_o <= 32'h0;
      end
      else
      begin
         done_o <= 1'b0;
         if (st_reg == H_IDLE)
         begin
            if (req_i)
            begin
               st_reg <= H_START;
               ph_reg <= P_SLAW;
               q_reg <= 2'h0;
               rd_reg <= rd_i;
               regad_reg <= reg_i;
               cnt_reg <= cnt_i;
               wd_reg <= wdata_i;
               nack_o <= 1'b0;
            end
         end
         else if (tick)
         begin
            q_reg <= q_reg + 2'h1;
            case (st_reg)
               H_START:
               begin
                  case (q_reg)
                     2'h0: sda_reg <= 1'b1;
                     2'h1: scl_reg <= 1'b1;
                     2'h2: sda_reg <= 1'b0;
                     default:
                     begin
                        scl_reg <= 1'b0;
                        st_reg <= H_BIT;
                        bitn_reg <= 4'h0;
                        tx_reg <= {SLAVE_ADDR, ph_reg != P_SLAW};                  // [RULE11]
                     end
                  endcase
               end
               H_BIT:
               begin
                  case (q_reg)
                     2'h0:
                     begin
                        if (bitn_reg < 4'h8)
                           sda_reg <= rxm | tx_reg[7];
                        else
                           sda_reg <= ~rxm | last;                                 // [RULE12] [RULE13]
                     end
                     2'h1: scl_reg <= 1'b1;
                     2'h2:
                     begin
                        if (bitn_reg < 4'h8)
                        begin
                           rx_reg <= {rx_reg[6:0], sda_s[1]};
                           tx_reg <= {tx_reg[6:0], 1'b0};
                        end
                        else
                           ackb_reg <= sda_s[1];
                     end
                     default:
                     begin
                        scl_reg <= 1'b0;
                        bitn_reg <= bitn_reg + 4'h1;
                        if (bitn_reg == 4'h8)
                        begin
                           bitn_reg <= 4'h0;
                           if (!rxm && ackb_reg)
                           begin
                              nack_o <= 1'b1;
                              st_reg <= H_STOP;
                           end
                           else
                           begin
                              case (ph_reg)
                                 P_SLAW:
                                 begin
                                    ph_reg <= P_REG;
                                    tx_reg <= {5'h00, regad_reg};                  // [RULE18]
                                 end
                                 P_REG:
                                 begin
                                    idx_reg <= 3'h0;
                                    if (rd_reg)
                                    begin
                                       ph_reg <= P_SLAR;
                                       st_reg <= H_START;
                                    end
                                    else
                                    begin
                                       ph_reg <= P_WDAT;
                                       tx_reg <= wd_reg[7:0];                      // [RULE3]
                                    end
                                 end
                                 P_WDAT:
                                 begin
                                    if (last)
                                       st_reg <= H_STOP;
                                    idx_reg <= idx_reg + 3'h1;
                                    tx_reg <= wd_reg[{idx_reg[1:0] + 2'h1, 3'b000} +: 8];
                                 end
                                 P_SLAR: ph_reg <= P_RDAT;
                                 default:
                                 begin
                                    rdata_o[{idx_reg[1:0], 3'b000} +: 8] <= rx_reg;
                                    if (last)
                                       st_reg <= H_STOP;
                                    idx_reg <= idx_reg + 3'h1;
                                 end
                              endcase
                           end
                        end
                     end
                  endcase
               end
               H_STOP:
               begin
                  case (q_reg)
                     2'h0: sda_reg <= 1'b0;
                     2'h1: scl_reg <= 1'b1;
                     2'h2: sda_reg <= 1'b1;
                     default:
                     begin
                        st_reg <= H_IDLE;
                        done_o <= 1'b1;
                     end
                  endcase
               end
               default: st_reg <= H_IDLE;
            endcase
         end
      end
   end

   assign busy_o = (st_reg != H_IDLE);
   assign bus.scl = scl_reg;
   assign bus.host_sda_o = 1'b0;
   assign bus.host_sda_oe_n = sda_reg;
endmodule

// ===== design/qpw_if.sv
// two-wire link between host and pot device
`timescale 1ns/1ps
interface qpw_if;
   logic scl;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic sda;
   // ----------------------------------------
   // open-drain wired level, pulled up
   // ----------------------------------------
   assign sda = ~((~dev_sda_oe_n & ~dev_sda_o) | (~host_sda_oe_n & ~host_sda_o));
   modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
   modport host (output scl, input sda, output host_sda_o, output host_sda_oe_n);
endinterface

// ===== design/qpw_pkg.sv
// shared constants and types for the quad pot two-wire link
package qpw_pkg;
   // ----------------------------------------
   // addressing
   // ----------------------------------------
   localparam logic [6:0] DEV_ADDR_DEF = 7'h28;
   localparam logic [2:0] ADDR_SELECT = 3'h7;
   localparam int CHANNELS = 4;
   localparam int SR_NV_BIT = 0;
   localparam int SR_ROW_LSB = 1;
   localparam logic [2:0] SR_RST = 3'h0;
   localparam logic [1:0] CH_RST = 2'h0;
   localparam logic [7:0] STORED_RST = 8'h00;
   localparam logic [7:0] WIPER_RST = 8'h00;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int NVW_TIME_NS = 1000;
   localparam int NVW_CYCLES = (NVW_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int QTR_CYCLES = 5;
   // ----------------------------------------
   // state encodings
   // ----------------------------------------
   typedef enum logic [2:0] {
      D_IDLE = 3'b000,
      D_SLV = 3'b001,
      D_REG = 3'b010,
      D_WDAT = 3'b011,
      D_RDAT = 3'b100,
      D_NVW = 3'b101
   } qpw_dst_e;
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_START = 2'b01,
      H_BIT = 2'b10,
      H_STOP = 2'b11
   } qpw_hst_e;
   typedef enum logic [2:0] {
      P_SLAW = 3'b000,
      P_REG = 3'b001,
      P_WDAT = 3'b010,
      P_SLAR = 3'b011,
      P_RDAT = 3'b100
   } qpw_ph_e;
endpackage

// ===== test/qpw_link_props.sv
// assertions on the two-wire link between host and pot device
`timescale 1ns/1ps
module qpw_link_props #(parameter int NV_CYC = 200)
(
   input wire logic mclk_i, // clock
   input wire logic arst_n_i, // reset, active low
   input wire logic scl_i, // link clock level
   input wire logic sda_i, // wired data level
   input wire logic dev_sda_i, // device data
   input wire logic dev_sda_oe_n_i, // device pull, active low
   input wire logic nv_busy_i, // write cycle running
   input wire logic wp_n_i // write protect, active low
);
   // ------------------------------
   // write cycle length counter
   // ------------------------------
   logic [15:0] cnt_reg;
   always_ff @(posedge mclk_i or negedge arst_n_i)
      if (!arst_n_i)
         cnt_reg <= 16'h0000;
      else
         cnt_reg <= nv_busy_i ? cnt_reg + 16'h0001 : 16'h0000;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);
   a_busy_released: assert property (nv_busy_i |-> dev_sda_oe_n_i)
      else $error("device pulls data while busy");
   a_busy_length: assert property ($fell(nv_busy_i) |-> cnt_reg == NV_CYC)
      else $error("write cycle length wrong");
   a_busy_minimum: assert property ($rose(nv_busy_i) |=> nv_busy_i [*8])
      else $error("write cycle cut short");
   a_commit_at_stop: assert property ($rose(nv_busy_i) |-> scl_i && sda_i)
      else $error("write cycle without stop");
   a_commit_wp_high: assert property ($rose(nv_busy_i) |-> wp_n_i)
      else $error("write cycle while protected");
   a_ack_scl_low: assert property ($fell(dev_sda_oe_n_i) |-> !scl_i)
      else $error("device pulls data while clock high");
   a_release_scl_low: assert property ($rose(dev_sda_oe_n_i) |-> !scl_i)
      else $error("device releases data while clock high");
   a_pull_level: assert property (!dev_sda_oe_n_i |-> !dev_sda_i && !sda_i)
      else $error("device pull does not give low");
endmodule

// ===== test/tb_quad_pot_page_write_move_read.sv
// bench: host and pot device joined over the two-wire link
`timescale 1ns/1ps
module tb_quad_pot_page_write_move_read;
   import qpw_pkg::*;
   logic mclk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic wp_n_i = 1'b1;
   logic req_i = 1'b0;
   logic rd_i = 1'b0;
   logic [2:0] reg_i = 3'h0;
   logic [2:0] cnt_i = 3'h4;
   logic [31:0] wdata_i = 32'h00000000;
   logic busy_o, done_o, nack_o, nv_busy_o;
   logic [31:0] rdata_o, wiper_o;
   logic [7:0] row_m [4][4];
   logic [7:0] wip_m [4];
   logic [2:0] sel_m = 3'h0;
   logic [65:0] note_q [$];
   logic [65:0] note;
   int bad_count = 0;
   int check_count = 0;
   int cycles = 0;
   int seed = 83;
   int r;
   qpw_if link();
   qpw_dev qpw_dev_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .bus(link), .wp_n_i(wp_n_i), .wiper_o(wiper_o),
      .nv_busy_o(nv_busy_o));
   qpw_host qpw_host_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .bus(link), .req_i(req_i), .rd_i(rd_i),
      .reg_i(reg_i), .cnt_i(cnt_i), .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o), .nack_o(nack_o),
      .rdata_o(rdata_o));
   qpw_link_props #(.NV_CYC(NVW_CYCLES)) qpw_link_props_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
      .scl_i(link.scl), .sda_i(link.sda), .dev_sda_i(link.dev_sda_o), .dev_sda_oe_n_i(link.dev_sda_oe_n),
      .nv_busy_i(nv_busy_o), .wp_n_i(wp_n_i));
   always #2.5 mclk_i = ~mclk_i;
   // ------------------------------
   // reporting
   // ------------------------------
   task print_verdict();
      $display("checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // note holds expected value over its mask
   task check(input logic [32:0] got, input logic [65:0] n, input string what);
      check_count++;
      if (((got ^ n[65:33]) & n[32:0]) !== 33'h000000000)
      begin
         bad_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, n[65:33]);
      end
   endtask
   always @(posedge mclk_i)
   begin
      cycles++;
      if (done_o === 1'b1)
      begin
         note = note_q.pop_front();
         check({nack_o, rdata_o}, note, "transfer");
      end
      if (cycles == 40000)
      begin
         bad_count++;
         print_verdict();
      end
   end
   // ------------------------------
   // transfers
   // ------------------------------
   task automatic xfer(input logic rd, input logic [2:0] ra, input logic [2:0] n, input logic [31:0] wd,
      input logic [65:0] exp);
      note_q.push_back(exp);
      rd_i = rd;
      reg_i = ra;
      cnt_i = n;
      wdata_i = wd;
      req_i = 1'b1;
      @(posedge mclk_i);
      #1 req_i = 1'b0;
      check({32'h0, busy_o}, {33'h000000001, 33'h000000001}, "busy");
      while (done_o !== 1'b1)
      begin
         @(posedge mclk_i);
         #1;
      end
      @(posedge mclk_i);
      #1;
   endtask
   task chk_wip();
      check({1'b0, wiper_o}, {1'b0, wip_m[3], wip_m[2], wip_m[1], wip_m[0], 33'h0FFFFFFFF}, "wiper");
   endtask
   task automatic wr(input logic [2:0] ra, input logic [2:0] n, input logic [31:0] wd, input bit quick);
      logic [7:0] bf [4];
      logic [3:0] hit;
      int k;
      hit = 4'h0;
      for (k = 0; k < ((n == 3'h0) ? 8 : n); k++)
      begin
         bf[(ra + k) % 4] = wd[8 * (k % 4) +: 8];
         hit[(ra + k) % 4] = 1'b1;
      end
      if (ra == ADDR_SELECT)
         sel_m = wd[2:0];
      for (k = 0; k < 4; k++)
         if (ra == ADDR_SELECT && sel_m[0])
            wip_m[k] = row_m[sel_m[2:1]][k];
         else if (ra < 3'h4 && !sel_m[0] && hit[k])
            wip_m[k] = bf[k];
         else if (ra < 3'h4 && sel_m[0] && wp_n_i)
         begin
            if (hit[k])
               row_m[sel_m[2:1]][k] = bf[k];
            wip_m[k] = row_m[sel_m[2:1]][k];
         end
      xfer(1'b0, ra, n, wd, {33'h000000000, 33'h100000000});
      if (!quick)
      begin
         repeat (NVW_CYCLES + 20) @(posedge mclk_i);
         #1;
         chk_wip();
      end
   endtask
   task automatic rd(input logic [2:0] ra, input logic [2:0] n);
      logic [31:0] ex;
      int k;
      for (k = 0; k < 4; k++)
         ex[8 * k +: 8] = sel_m[0] ? row_m[sel_m[2:1]][(ra + k) % 4] : wip_m[(ra + k) % 4];
      if (sel_m[0])
         wip_m = row_m[sel_m[2:1]];
      xfer(1'b1, ra, n, 32'h00000000, {1'b0, ex, 33'h1FFFFFFFF});
      chk_wip();
   endtask
   initial
   begin
      for (r = 0; r < 16; r++)
         row_m[r / 4][r % 4] = STORED_RST;
      for (r = 0; r < 4; r++)
         wip_m[r] = WIPER_RST;
      repeat (6) @(posedge mclk_i);
      #1 arst_n_i = 1'b1;
      repeat (4) @(posedge mclk_i);
      #1;
      rd(3'h0, 3'h4);
      for (r = 0; r < 4; r++)
      begin
         wr(ADDR_SELECT, 3'h1, {29'h0, r[1:0], 1'b1}, 1'b0);
         wr(r[2:0], r[2:0] + 3'h3, $random(seed), 1'b0);
         rd({1'b0, r[1:0] + 2'h1}, r[2:0] + 3'h4);
      end
      wr(3'h2, 3'h0, $random(seed), 1'b0);
      wr(ADDR_SELECT, 3'h1, 32'h00000000, 1'b0);
      wr(3'h1, 3'h2, $random(seed), 1'b0);
      rd(3'h0, 3'h4);
      wr(ADDR_SELECT, 3'h1, 32'h00000005, 1'b0);
      wp_n_i = 1'b0;
      wr(3'h0, 3'h4, $random(seed), 1'b0);
      wp_n_i = 1'b1;
      // read issued while the write cycle runs must go unanswered
      wr(3'h3, 3'h1, $random(seed), 1'b1);
      xfer(1'b1, 3'h0, 3'h4, 32'h00000000, {33'h100000000, 33'h100000000});
      repeat (NVW_CYCLES + 20) @(posedge mclk_i);
      #1;
      rd(3'h0, 3'h4);
      print_verdict();
   end
endmodule
